// [sdm_status_mem.sv]
// Top of the state word and data memory map: flags, data RAM, SFR decode, fetch range.
// Assumes the execution unit drives all request inputs on the same clock.
import sdm_pkg::*;

// What this block does
// - Carry takes ALU bit 7 carry out.
// - Aux carry takes operand bit 3 carry.
// - Range flag on carry, borrow, muldiv overflow.
// - Parity recomputed each instruction cycle.
// - Two bank bits choose register bank.
// - Bits 5 and 1 are plain user flags.
// - Fetches served only from on-chip memory.
// - Fetch range is 0000h through 3FFFh.
// - Upper RAM only through indirect access.
// - Lower RAM through direct and indirect.
// - SFRs through direct and bit access, separate from RAM.
// - Low 32 bytes are four register banks.
// - Bytes 20h to 2Fh bit addressable.
// - State word sits at SFR D0h.
module sdm_status_mem (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic alu_upd_in,
    input wire sdm_pkg::sdm_alu_op_e alu_op_in,
    input wire logic [sdm_pkg::SDM_DW-1:0] alu_opnd_a_in,
    input wire logic [sdm_pkg::SDM_DW-1:0] alu_opnd_b_in,
    input wire logic alu_carry_in,
    input wire logic alu_muldiv_ovf_in,
    input wire logic instr_cycle_in,
    input wire logic [sdm_pkg::SDM_DW-1:0] acc_in,
    input wire logic mem_req_in,
    input wire logic mem_wr_in,
    input wire sdm_pkg::sdm_access_e mem_kind_in,
    input wire logic [7:0] mem_addr_in,
    input wire logic [sdm_pkg::SDM_DW-1:0] mem_wdata_in,
    input wire logic fetch_req_in,
    input wire logic [sdm_pkg::SDM_FETCH_AW-1:0] fetch_addr_in,
    output logic [sdm_pkg::SDM_DW-1:0] cpu_state_word_out,
    output logic [sdm_pkg::SDM_DW-1:0] mem_rdata_out,
    output logic mem_ack_out,
    output logic [sdm_pkg::SDM_CODE_AW-1:0] code_addr_out,
    output logic code_valid_out,
    output logic fetch_fault_out
);
    import sdm_pkg::*;

    // ****************************************************************
    // Storage and sub-blocks
    // ****************************************************************
    logic [SDM_DW-1:0] ram_mem [SDM_RAM_DEPTH];
    logic [SDM_DW-1:0] state_word_ff;
    logic [SDM_DW-1:0] nxt_state_word;
    logic [SDM_DW-1:0] rdata_ff;
    logic [SDM_DW-1:0] nxt_rdata;
    logic ack_ff;
    logic nxt_ack;
    logic [SDM_CODE_AW-1:0] code_addr_ff;
    logic [SDM_CODE_AW-1:0] nxt_code_addr;
    logic code_valid_ff;
    logic nxt_code_valid;
    logic fetch_fault_ff;
    logic nxt_fetch_fault;
    logic ram_we;
    logic [SDM_DW-1:0] ram_wbyte;
    logic [SDM_DW-1:0] rd_byte;
    logic [SDM_DW-1:0] new_byte;
    logic sfr_is_state;

    sdm_core_if cif ();

    sdm_flag_unit u_flags (
        .fif(cif.flag_mp)
    );

    sdm_addr_dec u_dec (
        .dif(cif.dec_mp)
    );

    // Requests feed the shared interface; the bank comes from the live state word.
    assign cif.op = alu_op_in;
    assign cif.opnd_a = alu_opnd_a_in;
    assign cif.opnd_b = alu_opnd_b_in;
    assign cif.carry_in = alu_carry_in;
    assign cif.muldiv_ovf = alu_muldiv_ovf_in;
    assign cif.kind = mem_kind_in;
    assign cif.addr = mem_addr_in;
    assign cif.bank = state_word_ff[SDM_BANK_HIGH_BIT:SDM_BANK_LOW_BIT];

    // ****************************************************************
    // Data access and state word update
    // ****************************************************************

    // Only the state word is held in the SFR space here; other SFRs read zero.
    always_comb begin
        sfr_is_state = cif.to_sfr && (cif.byte_addr == SDM_STATE_WORD_ADDR);
        rd_byte = 8'h00;
        if (cif.to_ram) begin
            rd_byte = ram_mem[cif.byte_addr];
        end else if (sfr_is_state) begin
            rd_byte = state_word_ff;
        end
        new_byte = mem_wdata_in;
        if (mem_kind_in == SDM_ACC_BIT) begin
            new_byte = rd_byte;
            new_byte[cif.bit_pos] = mem_wdata_in[0];
        end
    end

    // Software writes land first, hardware flag updates override them, and the
    // parity bit is never software writable.
    always_comb begin
        nxt_state_word = state_word_ff;
        nxt_rdata = rdata_ff;
        nxt_ack = 1'b0;
        ram_we = 1'b0;
        ram_wbyte = new_byte;
        if (mem_req_in) begin
            nxt_ack = 1'b1;
            if (mem_kind_in == SDM_ACC_BIT) begin
                nxt_rdata = {7'h00, rd_byte[cif.bit_pos]};
            end else begin
                nxt_rdata = rd_byte;
            end
            if (mem_wr_in && cif.to_ram) begin
                ram_we = 1'b1;
            end
            if (mem_wr_in && sfr_is_state) begin
                nxt_state_word = {new_byte[7:1], state_word_ff[SDM_PARITY_BIT]};
            end
        end
        if (alu_upd_in) begin
            nxt_state_word[SDM_CARRY_BIT] = cif.cy;
            nxt_state_word[SDM_AUX_CARRY_BIT] = cif.ac;
            nxt_state_word[SDM_RANGE_BIT] = cif.ov;
        end
        if (instr_cycle_in) begin
            nxt_state_word[SDM_PARITY_BIT] = ^acc_in;
        end
    end

    // Registers for the state word and the access answer.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_word_ff <= SDM_STATE_WORD_RST;
            rdata_ff <= 8'h00;
            ack_ff <= 1'b0;
        end else begin
            state_word_ff <= nxt_state_word;
            rdata_ff <= nxt_rdata;
            ack_ff <= nxt_ack;
        end
    end

    // The RAM array has no reset; upper bytes share no storage with SFRs.
    always_ff @(posedge sys_clk_in) begin
        if (ram_we) begin
            ram_mem[cif.byte_addr] <= ram_wbyte;
        end
    end

    // ****************************************************************
    // Program fetch range
    // ****************************************************************

    // Fetches outside the on-chip range raise a fault; there is no external path.
    always_comb begin
        nxt_code_addr = code_addr_ff;
        nxt_code_valid = 1'b0;
        nxt_fetch_fault = 1'b0;
        if (fetch_req_in) begin
            nxt_code_addr = fetch_addr_in[SDM_CODE_AW-1:0];
            nxt_code_valid = (fetch_addr_in >= SDM_CODE_FIRST) && (fetch_addr_in <= SDM_CODE_LAST);
            nxt_fetch_fault = !nxt_code_valid;
        end
    end

    // Registers for the fetch answer.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            code_addr_ff <= 14'h0000;
            code_valid_ff <= 1'b0;
            fetch_fault_ff <= 1'b0;
        end else begin
            code_addr_ff <= nxt_code_addr;
            code_valid_ff <= nxt_code_valid;
            fetch_fault_ff <= nxt_fetch_fault;
        end
    end

    // Outputs come straight from registers.
    assign cpu_state_word_out = state_word_ff;
    assign mem_rdata_out = rdata_ff;
    assign mem_ack_out = ack_ff;
    assign code_addr_out = code_addr_ff;
    assign code_valid_out = code_valid_ff;
    assign fetch_fault_out = fetch_fault_ff;

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [8:0] chk_add9;
    logic [4:0] chk_addn;
    logic chk_add_cy;
    logic chk_add_ac;
    logic chk_sub_cy;
    logic [8:0] chk_sub9;

    // Independent reference arithmetic for the flag checks.
    always_comb begin
        chk_add9 = {1'b0, alu_opnd_a_in} + {1'b0, alu_opnd_b_in} + {8'h00, alu_carry_in};
        chk_addn = {1'b0, alu_opnd_a_in[3:0]} + {1'b0, alu_opnd_b_in[3:0]} + {4'h0, alu_carry_in};
        chk_sub9 = {1'b0, alu_opnd_a_in} - {1'b0, alu_opnd_b_in} - {8'h00, alu_carry_in};
        chk_add_cy = chk_add9[8];
        chk_add_ac = chk_addn[4];
        chk_sub_cy = chk_sub9[8];
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);

    a_carry_add_sub: assert property (
        alu_upd_in && (alu_op_in == SDM_OP_ADD || alu_op_in == SDM_OP_SUB) |=>
        state_word_ff[SDM_CARRY_BIT] == ($past(alu_op_in) == SDM_OP_ADD ? $past(chk_add_cy) : $past(chk_sub_cy)))
        else $error("Carry flag does not match ALU carry out.");
    a_aux_carry_add: assert property (
        alu_upd_in && alu_op_in == SDM_OP_ADD |=> state_word_ff[SDM_AUX_CARRY_BIT] == $past(chk_add_ac))
        else $error("Aux carry flag does not match nibble carry.");
    a_range_muldiv: assert property (
        alu_upd_in && alu_op_in == SDM_OP_MULDIV |=>
        state_word_ff[SDM_RANGE_BIT] == $past(alu_muldiv_ovf_in) && !state_word_ff[SDM_CARRY_BIT])
        else $error("Range flag wrong after multiply or divide.");
    a_parity_even: assert property (
        instr_cycle_in |=> state_word_ff[SDM_PARITY_BIT] == ^$past(acc_in))
        else $error("Parity bit does not give even parity.");
    a_bank_register: assert property (
        mem_req_in && mem_kind_in == SDM_ACC_REG |->
        cif.to_ram && cif.byte_addr == {3'h0, state_word_ff[4:3], mem_addr_in[2:0]})
        else $error("Register operand decoded to the wrong bank.");
    a_user_flags: assert property (
        mem_req_in && mem_wr_in && mem_kind_in == SDM_ACC_DIRECT && mem_addr_in == SDM_STATE_WORD_ADDR
        |=> state_word_ff[SDM_USER_ZERO_BIT] == $past(mem_wdata_in[5])
        && state_word_ff[SDM_USER_ONE_BIT] == $past(mem_wdata_in[1]))
        else $error("User flags do not hold the written value.");
    a_fetch_range: assert property (
        fetch_req_in |=> code_valid_out == ($past(fetch_addr_in) <= SDM_CODE_LAST) && fetch_fault_out == !code_valid_out)
        else $error("Fetch range decode is wrong.");
    a_upper_direct: assert property (
        mem_req_in && mem_kind_in == SDM_ACC_DIRECT && mem_addr_in >= SDM_DIRECT_LIMIT |-> !cif.to_ram && cif.to_sfr)
        else $error("Direct upper address reached the RAM.");
    a_lower_both: assert property (
        mem_req_in && mem_kind_in inside {SDM_ACC_DIRECT, SDM_ACC_INDIRECT} && mem_addr_in < SDM_DIRECT_LIMIT
        |-> cif.to_ram && cif.byte_addr == mem_addr_in)
        else $error("Lower RAM not reached by direct or indirect access.");
    a_bit_map: assert property (
        mem_req_in && mem_kind_in == SDM_ACC_BIT && mem_addr_in < SDM_DIRECT_LIMIT |->
        cif.to_ram && cif.byte_addr == 8'h20 + (mem_addr_in >> 3) && cif.bit_pos == mem_addr_in[2:0])
        else $error("Bit address mapped to the wrong byte or bit.");
    a_state_word_sfr: assert property (
        mem_req_in && !mem_wr_in && mem_kind_in == SDM_ACC_DIRECT && mem_addr_in == SDM_STATE_WORD_ADDR
        |=> mem_ack_out && mem_rdata_out == $past(state_word_ff))
        else $error("State word not read at its SFR address.");

    c_state_word_write: cover property (
        mem_req_in && mem_wr_in && mem_kind_in == SDM_ACC_DIRECT && mem_addr_in == SDM_STATE_WORD_ADDR);
    c_bit_write_ram: cover property (mem_req_in && mem_wr_in && mem_kind_in == SDM_ACC_BIT && cif.to_ram);
    c_bank_three: cover property (mem_req_in && mem_kind_in == SDM_ACC_REG && state_word_ff[4:3] == 2'h3);
    c_fetch_fault: cover property (fetch_req_in ##1 fetch_fault_out);
endmodule : sdm_status_mem

// [sdm_pkg.sv]
// Shared constants and types for the status word and data memory map block.
// Assumes a single CPU clock domain and an execution unit on the same clock.
package sdm_pkg;

    // ****************************************************************
    // Widths and address map
    // ****************************************************************
    localparam int SDM_DW = 8;
    localparam int SDM_CODE_AW = 14;
    localparam int SDM_FETCH_AW = 16;
    localparam int SDM_RAM_DEPTH = 256;
    localparam logic [7:0] SDM_DIRECT_LIMIT = 8'h80;
    localparam logic [7:0] SDM_BIT_RAM_BASE = 8'h20;
    localparam logic [7:0] SDM_STATE_WORD_ADDR = 8'hd0;
    localparam logic [15:0] SDM_CODE_FIRST = 16'h0000;
    localparam logic [15:0] SDM_CODE_LAST = 16'h3fff;

    // ****************************************************************
    // State word field positions and reset value
    // ****************************************************************
    localparam int SDM_CARRY_BIT = 7;
    localparam int SDM_AUX_CARRY_BIT = 6;
    localparam int SDM_USER_ZERO_BIT = 5;
    localparam int SDM_BANK_HIGH_BIT = 4;
    localparam int SDM_BANK_LOW_BIT = 3;
    localparam int SDM_RANGE_BIT = 2;
    localparam int SDM_USER_ONE_BIT = 1;
    localparam int SDM_PARITY_BIT = 0;
    localparam logic [7:0] SDM_STATE_WORD_RST = 8'h00;

    // ****************************************************************
    // Enumerations
    // ****************************************************************
    typedef enum logic [1:0] {
        SDM_OP_OTHER,
        SDM_OP_ADD,
        SDM_OP_SUB,
        SDM_OP_MULDIV
    } sdm_alu_op_e;

    typedef enum logic [1:0] {
        SDM_ACC_DIRECT,
        SDM_ACC_INDIRECT,
        SDM_ACC_REG,
        SDM_ACC_BIT
    } sdm_access_e;

endpackage : sdm_pkg

// [sdm_core_if.sv]
// Interface that joins the top module to its flag unit and address decoder.
// Assumes all three parties sit on one clock; every signal is combinational.
interface sdm_core_if;
    import sdm_pkg::*;

    // ALU side of the flag unit.
    sdm_alu_op_e op;
    logic [7:0] opnd_a;
    logic [7:0] opnd_b;
    logic carry_in;
    logic muldiv_ovf;
    logic cy;
    logic ac;
    logic ov;
    // Address decoder request and result.
    sdm_access_e kind;
    logic [7:0] addr;
    logic [1:0] bank;
    logic [7:0] byte_addr;
    logic [2:0] bit_pos;
    logic to_ram;
    logic to_sfr;

    modport flag_mp (input op, opnd_a, opnd_b, carry_in, muldiv_ovf, output cy, ac, ov);
    modport dec_mp (input kind, addr, bank, output byte_addr, bit_pos, to_ram, to_sfr);
    modport top_mp (output op, opnd_a, opnd_b, carry_in, muldiv_ovf, kind, addr, bank,
                    input cy, ac, ov, byte_addr, bit_pos, to_ram, to_sfr);
endinterface : sdm_core_if

// [sdm_flag_unit.sv]
// Combinational carry, auxiliary carry and range flag computation.
// Assumes operands and carry are stable for the cycle in which they are applied.
module sdm_flag_unit (
    sdm_core_if.flag_mp fif
);
    import sdm_pkg::*;

    // ****************************************************************
    // Flag arithmetic
    // ****************************************************************
    logic [8:0] full_res;
    logic [4:0] nib_res;

    // Bit 8 of the wide result is the carry or borrow out of bit 7; bit 4 of the
    // nibble result is the carry into or borrow from the upper nibble.
    always_comb begin
        full_res = 9'h000;
        nib_res = 5'h00;
        fif.cy = 1'b0;
        fif.ac = 1'b0;
        fif.ov = 1'b0;
        case (fif.op)
            SDM_OP_ADD: begin
                full_res = {1'b0, fif.opnd_a} + {1'b0, fif.opnd_b} + {8'h00, fif.carry_in};
                nib_res = {1'b0, fif.opnd_a[3:0]} + {1'b0, fif.opnd_b[3:0]} + {4'h0, fif.carry_in};
                fif.cy = full_res[8];
                fif.ac = nib_res[4];
                fif.ov = full_res[8];
            end
            SDM_OP_SUB: begin
                full_res = {1'b0, fif.opnd_a} - {1'b0, fif.opnd_b} - {8'h00, fif.carry_in};
                nib_res = {1'b0, fif.opnd_a[3:0]} - {1'b0, fif.opnd_b[3:0]} - {4'h0, fif.carry_in};
                fif.cy = full_res[8];
                fif.ac = nib_res[4];
                fif.ov = full_res[8];
            end
            SDM_OP_MULDIV: begin
                fif.ov = fif.muldiv_ovf;
            end
            default: begin
                fif.cy = 1'b0;
            end
        endcase
    end
endmodule : sdm_flag_unit

// [sdm_addr_dec.sv]
// Combinational decoder from an access kind and address to RAM or SFR storage.
// Assumes the caller supplies the active bank from the state word.
module sdm_addr_dec (
    sdm_core_if.dec_mp dif
);
    import sdm_pkg::*;

    // ****************************************************************
    // Address decode
    // ****************************************************************

    // Direct upper addresses go to SFRs; indirect always goes to RAM.
    always_comb begin
        dif.byte_addr = dif.addr;
        dif.bit_pos = 3'h0;
        dif.to_ram = 1'b0;
        dif.to_sfr = 1'b0;
        case (dif.kind)
            SDM_ACC_DIRECT: begin
                dif.to_ram = (dif.addr < SDM_DIRECT_LIMIT);
                dif.to_sfr = (dif.addr >= SDM_DIRECT_LIMIT);
            end
            SDM_ACC_INDIRECT: begin
                dif.to_ram = 1'b1;
            end
            SDM_ACC_REG: begin
                dif.byte_addr = {3'h0, dif.bank, dif.addr[2:0]};
                dif.to_ram = 1'b1;
            end
            SDM_ACC_BIT: begin
                dif.bit_pos = dif.addr[2:0];
                if (dif.addr < SDM_DIRECT_LIMIT) begin
                    dif.byte_addr = SDM_BIT_RAM_BASE + {4'h0, dif.addr[6:3]};
                    dif.to_ram = 1'b1;
                end else begin
                    dif.byte_addr = {dif.addr[7:3], 3'h0};
                    dif.to_sfr = 1'b1;
                end
            end
            default: begin
                dif.to_ram = 1'b0;
            end
        endcase
    end
endmodule : sdm_addr_dec

// [sdm_exec_model.sv]
// Behavioural execution unit that issues data, flag, parity and fetch requests.
// Assumes one free-running CPU clock and tasks called from a single bench process.
module sdm_exec_model
    import sdm_pkg::*;
(
    input wire logic clk_in,
    input wire logic [7:0] mem_rdata_in,
    input wire logic mem_ack_in,
    output logic alu_upd_out,
    output sdm_pkg::sdm_alu_op_e alu_op_out,
    output logic [7:0] alu_opnd_a_out,
    output logic [7:0] alu_opnd_b_out,
    output logic alu_carry_out,
    output logic alu_muldiv_ovf_out,
    output logic instr_cycle_out,
    output logic [7:0] acc_out,
    output logic mem_req_out,
    output logic mem_wr_out,
    output sdm_pkg::sdm_access_e mem_kind_out,
    output logic [7:0] mem_addr_out,
    output logic [7:0] mem_wdata_out,
    output logic fetch_req_out,
    output logic [15:0] fetch_addr_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Request drivers
    // ****************************************************************

    // Every line starts idle and defined at time zero.
    initial begin
        {alu_upd_out, alu_carry_out, alu_muldiv_ovf_out, instr_cycle_out} = 4'h0;
        {mem_req_out, mem_wr_out, fetch_req_out} = 3'h0;
        alu_op_out = SDM_OP_OTHER;
        mem_kind_out = SDM_ACC_DIRECT;
        {alu_opnd_a_out, alu_opnd_b_out, acc_out, mem_addr_out, mem_wdata_out} = 40'h0;
        fetch_addr_out = 16'h0000;
    end

    // One data access; the answer is taken one edge after the request.
    // Released request, write, address and data lines show the inverse so that stale values never look valid.
    task automatic mem_acc(input logic wr, input sdm_access_e kind, input logic [7:0] addr,
                           input logic [7:0] wdata, output logic [7:0] rdata, output logic ack);
        @(posedge clk_in);
        #1;
        mem_req_out = 1'b1;
        mem_wr_out = wr;
        mem_kind_out = kind;
        mem_addr_out = addr;
        mem_wdata_out = wdata;
        @(posedge clk_in);
        #1;
        rdata = mem_rdata_in;
        ack = mem_ack_in;
        mem_req_out = 1'b0;
        mem_wr_out = ~wr;
        mem_addr_out = ~addr;
        mem_wdata_out = ~wdata;
    endtask : mem_acc

    // One arithmetic flag update, held for a single taking edge.
    task automatic alu_op(input sdm_alu_op_e op, input logic [7:0] a, input logic [7:0] b,
                          input logic cin, input logic ovf);
        @(posedge clk_in);
        #1;
        alu_upd_out = 1'b1;
        alu_op_out = op;
        alu_opnd_a_out = a;
        alu_opnd_b_out = b;
        alu_carry_out = cin;
        alu_muldiv_ovf_out = ovf;
        @(posedge clk_in);
        #1;
        alu_upd_out = 1'b0;
        alu_opnd_a_out = ~a;
        alu_opnd_b_out = ~b;
    endtask : alu_op

    // One instruction cycle boundary carrying the accumulator value.
    task automatic instr_cycle(input logic [7:0] acc);
        @(posedge clk_in);
        #1;
        instr_cycle_out = 1'b1;
        acc_out = acc;
        @(posedge clk_in);
        #1;
        instr_cycle_out = 1'b0;
        acc_out = ~acc;
    endtask : instr_cycle

    // One instruction fetch request.
    task automatic fetch(input logic [15:0] addr);
        @(posedge clk_in);
        #1;
        fetch_req_out = 1'b1;
        fetch_addr_out = addr;
        @(posedge clk_in);
        #1;
        fetch_req_out = 1'b0;
        fetch_addr_out = ~addr;
    endtask : fetch
endmodule : sdm_exec_model

// [sdm_status_mem_tb_top.sv]
// Self-checking bench for the state word and data memory map block.
// Assumes the execution unit model drives every request input of the block.
module sdm_status_mem_tb_top
    import sdm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Clock, reset, wiring and checking helpers
    // ****************************************************************
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic alu_upd, alu_carry, alu_ovf, instr_cycle, mem_req, mem_wr, mem_ack, fetch_req;
    logic code_valid, fetch_fault;
    logic [7:0] opnd_a, opnd_b, acc, mem_addr, mem_wdata, mem_rdata, state_word, rd, sw_exp;
    logic [15:0] fetch_addr;
    logic [13:0] code_addr;
    sdm_alu_op_e alu_op;
    sdm_access_e mem_kind;
    logic [7:0] acc_vals [5] = '{8'h01, 8'h03, 8'hff, 8'h80, 8'hb6};
    logic [15:0] fetch_vals [5] = '{16'h0000, 16'h3fff, 16'h4000, 16'hffff, 16'h1234};
    int err_total = 0;
    int checks_done = 0;

    // The CPU clock toggles every half period of 10 ns, a 20 ns period.
    always #10 sys_clk = ~sys_clk;

    sdm_exec_model i_exec (.clk_in(sys_clk), .mem_rdata_in(mem_rdata), .mem_ack_in(mem_ack),
        .alu_upd_out(alu_upd), .alu_op_out(alu_op), .alu_opnd_a_out(opnd_a), .alu_opnd_b_out(opnd_b),
        .alu_carry_out(alu_carry), .alu_muldiv_ovf_out(alu_ovf), .instr_cycle_out(instr_cycle),
        .acc_out(acc), .mem_req_out(mem_req), .mem_wr_out(mem_wr), .mem_kind_out(mem_kind),
        .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata), .fetch_req_out(fetch_req),
        .fetch_addr_out(fetch_addr));

    sdm_status_mem i_dut (.sys_clk_in(sys_clk), .arst_n_in(arst_n), .alu_upd_in(alu_upd),
        .alu_op_in(alu_op), .alu_opnd_a_in(opnd_a), .alu_opnd_b_in(opnd_b), .alu_carry_in(alu_carry),
        .alu_muldiv_ovf_in(alu_ovf), .instr_cycle_in(instr_cycle), .acc_in(acc), .mem_req_in(mem_req),
        .mem_wr_in(mem_wr), .mem_kind_in(mem_kind), .mem_addr_in(mem_addr), .mem_wdata_in(mem_wdata),
        .fetch_req_in(fetch_req), .fetch_addr_in(fetch_addr), .cpu_state_word_out(state_word),
        .mem_rdata_out(mem_rdata), .mem_ack_out(mem_ack), .code_addr_out(code_addr),
        .code_valid_out(code_valid), .fetch_fault_out(fetch_fault));

    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Prints the counts and the verdict, then ends the run.
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    // One data access whose acknowledge must follow one cycle later.
    task automatic acc_do(input logic wr, input sdm_access_e kind, input logic [7:0] addr,
                          input logic [7:0] wdata);
        logic ack;
        i_exec.mem_acc(wr, kind, addr, wdata, rd, ack);
        chk(16'(ack), 16'h0001);
    endtask : acc_do

    // Applies one flag update and checks carry, aux carry and range flag.
    task automatic alu_case(input sdm_alu_op_e op, input logic [7:0] a, input logic [7:0] b,
                            input logic cin, input logic ovf);
        logic [8:0] full;
        logic [4:0] half;
        full = 9'h000;
        half = 5'h00;
        if (op == SDM_OP_ADD) begin
            full = 9'(a) + 9'(b) + 9'(cin);
            half = 5'(a[3:0]) + 5'(b[3:0]) + 5'(cin);
        end else if (op == SDM_OP_SUB) begin
            full = 9'(a) - 9'(b) - 9'(cin);
            half = 5'(a[3:0]) - 5'(b[3:0]) - 5'(cin);
        end
        sw_exp[7] = full[8];
        sw_exp[6] = half[4];
        sw_exp[2] = (op == SDM_OP_MULDIV) ? ovf : full[8];
        i_exec.alu_op(op, a, b, cin, ovf);
        chk(16'(state_word), 16'(sw_exp));
    endtask : alu_case

    // A hang is cut short and counted as a mismatch.
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        results();
    end

    // Main sequence of scenarios.
    initial begin
        repeat (20) @(posedge sys_clk);
        #1;
        arst_n = 1'b1;
        chk(16'(state_word), 16'h0000);
        acc_do(1'b1, SDM_ACC_DIRECT, SDM_STATE_WORD_ADDR, 8'h23);
        chk(16'(state_word), 16'h0022);
        acc_do(1'b0, SDM_ACC_DIRECT, SDM_STATE_WORD_ADDR, 8'h00);
        chk(16'(rd), 16'h0022);
        // Each bank holds its own register; the direct alias proves the base.
        for (int b = 0; b < 4; b++) begin
            acc_do(1'b1, SDM_ACC_DIRECT, SDM_STATE_WORD_ADDR, {3'h0, 2'(b), 3'h0});
            acc_do(1'b1, SDM_ACC_REG, 8'(7 - b), 8'h40 + 8'(b));
            acc_do(1'b0, SDM_ACC_DIRECT, 8'(b * 8 + 7 - b), 8'h00);
            chk(16'(rd), 16'h0040 + 16'(b));
        end
        sw_exp = 8'h18;
        acc_do(1'b1, SDM_ACC_INDIRECT, 8'h90, 8'h5a);
        acc_do(1'b0, SDM_ACC_DIRECT, 8'h90, 8'h00);
        chk(16'(rd), 16'h0000);
        acc_do(1'b0, SDM_ACC_INDIRECT, 8'h90, 8'h00);
        chk(16'(rd), 16'h005a);
        acc_do(1'b1, SDM_ACC_INDIRECT, 8'hd0, 8'hc3);
        chk(16'(state_word), 16'(sw_exp));
        acc_do(1'b0, SDM_ACC_INDIRECT, 8'hd0, 8'h00);
        chk(16'(rd), 16'h00c3);
        acc_do(1'b1, SDM_ACC_DIRECT, 8'h7f, 8'ha5);
        acc_do(1'b0, SDM_ACC_INDIRECT, 8'h7f, 8'h00);
        chk(16'(rd), 16'h00a5);
        // Bit 3 of byte 25h is bit address 2Bh.
        acc_do(1'b1, SDM_ACC_DIRECT, 8'h25, 8'h00);
        acc_do(1'b1, SDM_ACC_BIT, 8'h2b, 8'h01);
        acc_do(1'b0, SDM_ACC_DIRECT, 8'h25, 8'h00);
        chk(16'(rd), 16'h0008);
        acc_do(1'b0, SDM_ACC_BIT, 8'h2a, 8'h00);
        chk(16'(rd), 16'h0000);
        acc_do(1'b1, SDM_ACC_DIRECT, 8'h2f, 8'h80);
        acc_do(1'b0, SDM_ACC_BIT, 8'h7f, 8'h00);
        chk(16'(rd), 16'h0001);
        // Flag updates, including clears after sets and borrows.
        alu_case(SDM_OP_ADD, 8'hff, 8'h01, 1'b0, 1'b0);
        alu_case(SDM_OP_OTHER, 8'hff, 8'h01, 1'b0, 1'b1);
        alu_case(SDM_OP_ADD, 8'h0f, 8'h00, 1'b1, 1'b0);
        alu_case(SDM_OP_SUB, 8'h00, 8'h01, 1'b0, 1'b0);
        alu_case(SDM_OP_MULDIV, 8'h00, 8'h00, 1'b0, 1'b1);
        alu_case(SDM_OP_SUB, 8'h10, 8'h01, 1'b0, 1'b0);
        alu_case(SDM_OP_SUB, 8'h80, 8'h7f, 1'b1, 1'b0);
        alu_case(SDM_OP_ADD, 8'h01, 8'h02, 1'b0, 1'b0);
        alu_case(SDM_OP_MULDIV, 8'hff, 8'hff, 1'b1, 1'b0);
        // Parity follows the accumulator at each instruction cycle.
        foreach (acc_vals[i]) begin
            i_exec.instr_cycle(acc_vals[i]);
            sw_exp[0] = ^acc_vals[i];
            chk(16'(state_word), 16'(sw_exp));
        end
        // Bit address D5h is user flag zero inside the state word.
        acc_do(1'b1, SDM_ACC_BIT, 8'hd5, 8'h01);
        sw_exp[5] = 1'b1;
        chk(16'(state_word), 16'(sw_exp));
        // Fetches inside the on-chip range are valid, all others fault.
        foreach (fetch_vals[i]) begin
            i_exec.fetch(fetch_vals[i]);
            chk(16'({code_valid, fetch_fault}), (fetch_vals[i] <= 16'h3fff) ? 16'h0002 : 16'h0001);
            chk(16'(code_addr), 16'(fetch_vals[i][13:0]));
        end
        // A second reset in mid-run returns the state word to zero.
        arst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        arst_n = 1'b1;
        chk(16'(state_word), 16'h0000);
        results();
    end
endmodule : sdm_status_mem_tb_top
